/* logic/bwl_top.sv */
// bwl_top: boot watchdog with rom recovery, deep standby pins, led, button
// assumes a classic wishbone master on clk_i; pins asynchronous to clk_i
//
// Overview of operation
// - after power-up, release system reset and start the watchdog
// - no core ready before 7s or 20s: rails off, reset low, rom-hold low
// - in rom recovery wait 200ms, then restart the full power-up
// - rom-hold stays low through restart until reset is next released
// - recovery armed only after reset release and while enable bit set
// - optionally power-cycle the rails and reset, with rom-hold left high, when the watchdog expires
// - any individually enabled gpio can force deep standby in and out
// - pin eight can sink a breathing led, enabled by register
// - period codes pick 0.466 to 11.184s; duty codes 12.5 to 100%
// - period code 011 with duty code 101 gives 50% duty
// - press over 50ms makes device active and clears sleep bits
// - press under 50ms is ignored
// - pulse enabled: valid press gives 100ms pulse and unmasked irq
// - button-off powers off per its 2-bit hold window
// - power-off drops rails_on_o and holds system reset low in the same cycle
// - button-cycle power-cycles per its own 2-bit hold window
// - off and cycle may both be enabled with different hold windows
// - gpios are inputs with selectable polarity; only pin eight drives, as the open-drain led sink
`timescale 1ns/1ps
`default_nettype none
module bwl_top #(
  parameter int unsigned WD_SHORT_MS = bwl_pkg::WDOG_SHORT_MS,
  parameter int unsigned WD_LONG_MS  = bwl_pkg::WDOG_LONG_MS,
  parameter int unsigned ROMW_MS     = bwl_pkg::ROM_WAIT_MS,
  parameter int unsigned MS_CYC      = bwl_pkg::MS_DIV,
  parameter int unsigned DEB_MS      = bwl_pkg::DEBOUNCE_MS,
  parameter int unsigned S1_MS       = bwl_pkg::HOLD_1S_MS,
  parameter int unsigned S2_MS       = bwl_pkg::HOLD_2S_MS,
  parameter int unsigned S4_MS       = bwl_pkg::HOLD_4S_MS,
  parameter int unsigned S8_MS       = bwl_pkg::HOLD_8S_MS,
  parameter int unsigned S12_MS      = bwl_pkg::HOLD_12S_MS,
  parameter int unsigned PUL_MS      = bwl_pkg::PULSE_MS,
  parameter int unsigned US_DIV      = MS_CYC / 1000
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // power sequencer
  input  wire logic        seq_done_i,
  output logic             rails_on_o,
  // core
  input  wire logic        core_boot_ok_i,
  output logic             sys_rst_out_low_o,
  output logic             rom_hold_low_o,
  // button and interrupt
  input  wire logic        button_in_low_6_i,
  input  wire logic        button_in_low_7_i,
  output logic             irq_out_low_o,
  output logic             button_pulse_o,
  // gpio pins, open drain: oe low means pulling low
  input  wire logic [7:0]  gpio_i,
  output logic [7:0]       gpio_o,
  output logic [7:0]       gpio_oe_low_o,
  output logic             deep_standby_o
);
  logic [31:0] ctrl_r, btn_r, gpio_r;
  logic [16:0] ms_r;
  logic        ms_tick_r;
  logic [1:0]  boot_s_r, b6_s_r, b7_s_r;
  logic [7:0]  g_s1_r, g_s2_r, g_prev_r;
  logic [14:0] wd_r;
  logic        rom_on_r;
  logic        irq_r;
  bwl_pkg::bwl_state_t st_r;
  logic wake_w, off_w, cyc_w, pulse_w, led_w;
  logic [7:0] g_act_w;
  logic       rom_en_w;

  assign rom_en_w = ctrl_r[bwl_pkg::CTRL_ROM_EN];
  assign g_act_w  = g_s2_r ^ gpio_r[15:8];

  // core, button and gpio pins pass two flops before any logic reads them; seq_done_i is read directly
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boot_s_r <= 2'h0;
      b6_s_r   <= 2'h3;
      b7_s_r   <= 2'h3;
      g_s1_r   <= 8'h00;
      g_s2_r   <= 8'h00;
    end else begin
      boot_s_r <= {boot_s_r[0], core_boot_ok_i};
      b6_s_r   <= {b6_s_r[0], button_in_low_6_i};
      b7_s_r   <= {b7_s_r[0], button_in_low_7_i};
      g_s1_r   <= gpio_i;
      g_s2_r   <= g_s1_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || ms_r == 17'(MS_CYC - 1)) begin
      ms_r <= 17'h0;
    end else begin
      ms_r <= ms_r + 17'h1;
    end
    ms_tick_r <= !rst_i && ms_r == 17'(MS_CYC - 1);
  end

  bwl_button #(
    .DEB_MS(DEB_MS), .PUL_MS(PUL_MS), .S1_MS(S1_MS), .S2_MS(S2_MS),
    .S4_MS(S4_MS), .S8_MS(S8_MS), .S12_MS(S12_MS)
  ) u_button (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ms_tick_i (ms_tick_r),
    .pressed_i (btn_r[bwl_pkg::BTN_SRC7] ? !b7_s_r[1] : !b6_s_r[1]),
    .pulse_en_i(btn_r[bwl_pkg::BTN_PULSE_EN]),
    .off_en_i  (btn_r[bwl_pkg::BTN_OFF_EN]),
    .cyc_en_i  (btn_r[bwl_pkg::BTN_CYC_EN]),
    .off_sel_i (btn_r[bwl_pkg::BTN_OFF_LSB +: 2]),
    .cyc_sel_i (btn_r[bwl_pkg::BTN_CYC_LSB +: 2]),
    .wake_o    (wake_w),
    .off_o     (off_w),
    .cycle_o   (cyc_w),
    .pulse_o   (pulse_w)
  );

  bwl_blink #(.US_DIV(US_DIV)) u_blink (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .en_i    (ctrl_r[bwl_pkg::CTRL_LED_EN]),
    .period_i(ctrl_r[bwl_pkg::CTRL_PER_LSB +: 3]),
    .duty_i  (ctrl_r[bwl_pkg::CTRL_DUTY_LSB +: 3]),
    .sink_o  (led_w)
  );

  // power and recovery sequence; timers count milliseconds
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r     <= bwl_pkg::BWL_PWRUP;
      wd_r     <= 15'h0;
      rom_on_r <= 1'b0;
    end else begin
      case (st_r)
        bwl_pkg::BWL_OFF: begin
          wd_r <= 15'h0;
          if (wake_w) st_r <= bwl_pkg::BWL_PWRUP;
        end
        bwl_pkg::BWL_PWRUP: begin
          wd_r <= 15'h0;
          if (seq_done_i) begin
            rom_on_r <= 1'b0;
            st_r <= rom_en_w ? bwl_pkg::BWL_WATCH : bwl_pkg::BWL_RUN;
          end
        end
        bwl_pkg::BWL_WATCH: begin
          if (!rom_en_w || boot_s_r[1]) begin
            wd_r <= 15'h0;
            st_r <= bwl_pkg::BWL_RUN;
          end else if (wd_r == 15'(ctrl_r[bwl_pkg::CTRL_WD_LONG] ?
                                   WD_LONG_MS : WD_SHORT_MS)) begin
            wd_r <= 15'h0;
            rom_on_r <= !ctrl_r[bwl_pkg::CTRL_WD_CYCLE];
            st_r <= bwl_pkg::BWL_ROMWAIT;
          end else if (ms_tick_r) begin
            wd_r <= wd_r + 15'h1;
          end
        end
        bwl_pkg::BWL_ROMWAIT: begin
          if (wd_r == 15'(ROMW_MS)) begin
            wd_r <= 15'h0;
            st_r <= bwl_pkg::BWL_PWRUP;
          end else if (ms_tick_r) begin
            wd_r <= wd_r + 15'h1;
          end
        end
        default: begin
          wd_r <= 15'h0;
          if (off_w) st_r <= bwl_pkg::BWL_OFF;
          else if (cyc_w) st_r <= bwl_pkg::BWL_ROMWAIT;
        end
      endcase
      if (st_r != bwl_pkg::BWL_OFF && off_w) begin
        wd_r <= 15'h0;
        st_r <= bwl_pkg::BWL_OFF;
      end
    end
  end

  // register outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rails_on_o        <= 1'b0;
      sys_rst_out_low_o <= 1'b0;
      rom_hold_low_o    <= 1'b1;
      deep_standby_o    <= 1'b0;
      gpio_o            <= 8'h00;
      gpio_oe_low_o     <= 8'hFF;
      irq_out_low_o     <= 1'b1;
      button_pulse_o    <= 1'b0;
    end else begin
      rails_on_o <= st_r != bwl_pkg::BWL_OFF &&
                    st_r != bwl_pkg::BWL_ROMWAIT;
      sys_rst_out_low_o <= st_r == bwl_pkg::BWL_WATCH ||
                           st_r == bwl_pkg::BWL_RUN;
      rom_hold_low_o <= !rom_on_r;
      deep_standby_o <= ctrl_r[bwl_pkg::CTRL_DEEP];
      gpio_o         <= 8'h00;
      gpio_oe_low_o  <= {!led_w, 7'h7F};
      irq_out_low_o  <= !(irq_r && !ctrl_r[bwl_pkg::CTRL_IRQ_MASK]);
      button_pulse_o <= pulse_w;
    end
  end

  // wishbone slave, one wait state: ack one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r   <= bwl_pkg::CTRL_RESET;
      btn_r    <= bwl_pkg::BTN_RESET;
      gpio_r   <= bwl_pkg::GPIO_RESET;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      g_prev_r <= 8'h00;
      irq_r    <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      g_prev_r <= g_act_w;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        case (wb_adr_i)
          bwl_pkg::REG_CTRL:   wb_dat_o <= ctrl_r;
          bwl_pkg::REG_BUTTON: wb_dat_o <= btn_r;
          bwl_pkg::REG_GPIO:   wb_dat_o <= gpio_r;
          bwl_pkg::REG_STATUS: wb_dat_o <= {18'h0, irq_r, boot_s_r[1],
            rom_on_r, g_act_w, st_r};
          default:             wb_dat_o <= 32'h0;
        endcase
      end
      // writes land at the edge where the master samples ack high
      if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) begin
            case (wb_adr_i)
              bwl_pkg::REG_CTRL:   ctrl_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
              bwl_pkg::REG_BUTTON: btn_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
              bwl_pkg::REG_GPIO:   gpio_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
              default: ;
            endcase
          end
        end
        if (wb_adr_i == bwl_pkg::REG_STATUS && wb_sel_i[1] && wb_dat_i[10])
          irq_r <= 1'b0;
      end
      // hardware events win over software writes
      if (|((g_act_w & ~g_prev_r) & gpio_r[7:0])) begin
        ctrl_r[bwl_pkg::CTRL_DEEP] <= 1'b1;
      end else if (|((~g_act_w & g_prev_r) & gpio_r[7:0])) begin
        ctrl_r[bwl_pkg::CTRL_DEEP] <= 1'b0;
      end
      if (wake_w) begin
        ctrl_r[bwl_pkg::CTRL_SLEEP] <= 1'b0;
        ctrl_r[bwl_pkg::CTRL_DEEP]  <= 1'b0;
      end
      if (wake_w && btn_r[bwl_pkg::BTN_PULSE_EN]) irq_r <= 1'b1;
    end
  end

  chk_rom_hold_low: assert property (@(posedge clk_i)
    disable iff (rst_i)
    $fell(rom_on_r) |-> $past(st_r) == bwl_pkg::BWL_PWRUP)
    else $error("rom hold released outside power-up");
  chk_rails_rom: assert property (@(posedge clk_i)
    disable iff (rst_i)
    st_r == bwl_pkg::BWL_ROMWAIT |=> !rails_on_o)
    else $error("rails on during recovery wait");
  chk_wd_quiet: assert property (@(posedge clk_i)
    disable iff (rst_i)
    st_r == bwl_pkg::BWL_WATCH && !rom_en_w && !off_w
    |=> st_r == bwl_pkg::BWL_RUN && wd_r == 15'h0 && !rom_on_r)
    else $error("watchdog not stopped with enable clear");
  chk_rst_release: assert property (@(posedge clk_i)
    disable iff (rst_i)
    st_r == bwl_pkg::BWL_PWRUP |=> !sys_rst_out_low_o)
    else $error("system reset released during power-up");
  chk_wake_clears: assert property (@(posedge clk_i)
    disable iff (rst_i)
    wake_w |=> !ctrl_r[bwl_pkg::CTRL_SLEEP] && !ctrl_r[bwl_pkg::CTRL_DEEP])
    else $error("sleep bits not cleared on wake");
  chk_off_state: assert property (@(posedge clk_i)
    disable iff (rst_i)
    off_w |=> st_r == bwl_pkg::BWL_OFF ##1 !rails_on_o)
    else $error("power off not taken");
  chk_romwait_exit: assert property (@(posedge clk_i)
    disable iff (rst_i)
    st_r == bwl_pkg::BWL_ROMWAIT && wd_r == 15'(ROMW_MS) && !off_w
    |=> st_r == bwl_pkg::BWL_PWRUP)
    else $error("restart not taken after wait");
  chk_irq_mask: assert property (@(posedge clk_i)
    disable iff (rst_i)
    ctrl_r[bwl_pkg::CTRL_IRQ_MASK] |=> irq_out_low_o)
    else $error("masked interrupt asserted");
  cov_rom_entry: cover property (@(posedge clk_i) disable iff (rst_i)
    st_r == bwl_pkg::BWL_WATCH ##1 st_r == bwl_pkg::BWL_ROMWAIT);
  cov_boot_ok: cover property (@(posedge clk_i) disable iff (rst_i)
    st_r == bwl_pkg::BWL_WATCH ##1 st_r == bwl_pkg::BWL_RUN);
  cov_btn_off: cover property (@(posedge clk_i) disable iff (rst_i) off_w);
  cov_btn_cyc: cover property (@(posedge clk_i) disable iff (rst_i) cyc_w);
endmodule
`default_nettype wire

/* logic/bwl_pkg.sv */
// bwl_pkg: constants for the boot watchdog, led blinker and button logic
// assumes a 125 MHz clk_i; long counts are scaled by top-level parameters
package bwl_pkg;
  localparam int unsigned CLK_HZ        = 125000000;
  localparam int unsigned MS_DIV        = CLK_HZ / 1000;
  // times in milliseconds
  localparam int unsigned WDOG_SHORT_MS = 7000;
  localparam int unsigned WDOG_LONG_MS  = 20000;
  localparam int unsigned ROM_WAIT_MS   = 200;
  localparam int unsigned DEBOUNCE_MS   = 50;
  localparam int unsigned PULSE_MS      = 100;
  localparam int unsigned HOLD_1S_MS    = 1000;
  localparam int unsigned HOLD_2S_MS    = 2000;
  localparam int unsigned HOLD_4S_MS    = 4000;
  localparam int unsigned HOLD_8S_MS    = 8000;
  localparam int unsigned HOLD_12S_MS   = 12000;
  // blink period in microseconds, indexed by period code
  localparam int unsigned BLINK_US [8] = '{466000, 932000, 1864000,
    2796000, 3728000, 5590000, 7450000, 11184000};
  localparam logic [2:0] BLINK_ALT_PERIOD = 3'h3;
  localparam logic [2:0] BLINK_ALT_DUTY   = 3'h5;
  localparam logic [2:0] BLINK_HALF_DUTY  = 3'h3;
  // register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_BUTTON = 8'h04;
  localparam logic [7:0] REG_GPIO   = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  // ctrl fields
  localparam int unsigned CTRL_ROM_EN   = 0;
  localparam int unsigned CTRL_WD_LONG  = 1;
  localparam int unsigned CTRL_WD_CYCLE = 2;
  localparam int unsigned CTRL_LED_EN   = 3;
  localparam int unsigned CTRL_PER_LSB  = 4;
  localparam int unsigned CTRL_DUTY_LSB = 8;
  localparam int unsigned CTRL_SLEEP    = 12;
  localparam int unsigned CTRL_DEEP     = 13;
  localparam int unsigned CTRL_IRQ_MASK = 14;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
  // button fields
  localparam int unsigned BTN_PULSE_EN  = 0;
  localparam int unsigned BTN_OFF_EN    = 1;
  localparam int unsigned BTN_CYC_EN    = 2;
  localparam int unsigned BTN_OFF_LSB   = 4;
  localparam int unsigned BTN_CYC_LSB   = 6;
  localparam int unsigned BTN_SRC7      = 8;
  localparam logic [31:0] BTN_RESET     = 32'h0000_0000;
  // gpio: [7:0] wake enable, [15:8] polarity invert
  localparam logic [31:0] GPIO_RESET    = 32'h0000_0000;

  typedef enum logic [2:0] {
    BWL_OFF     = 3'b000,
    BWL_PWRUP   = 3'b001,
    BWL_WATCH   = 3'b010,
    BWL_RUN     = 3'b011,
    BWL_ROMWAIT = 3'b100
  } bwl_state_t;
endpackage

/* logic/bwl_blink.sv */
// bwl_blink: breathing-led sink driver with period and duty codes
// assumes synchronous reset and clock at bwl_pkg::CLK_HZ
`timescale 1ns/1ps
`default_nettype none
module bwl_blink #(
  parameter int unsigned US_DIV = 125
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // control
  input  wire logic       en_i,
  input  wire logic [2:0] period_i,
  input  wire logic [2:0] duty_i,
  // sink on (pull low)
  output logic            sink_o
);
  logic [7:0]  us_r;
  logic [23:0] pos_r;
  logic [23:0] per_w;
  logic [23:0] on_w;
  logic [2:0]  duty_w;

  always_comb begin
    per_w  = 24'(bwl_pkg::BLINK_US[period_i]);
    duty_w = duty_i;
    if (period_i == bwl_pkg::BLINK_ALT_PERIOD &&
        duty_i == bwl_pkg::BLINK_ALT_DUTY) begin
      duty_w = bwl_pkg::BLINK_HALF_DUTY;
    end
    on_w = 24'((per_w >> 3) * ({21'h0, duty_w} + 24'h1));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      us_r  <= 8'h00;
      pos_r <= 24'h0;
    end else if (us_r == 8'(US_DIV - 1)) begin
      us_r  <= 8'h00;
      pos_r <= (pos_r + 24'h1 >= per_w) ? 24'h0 : pos_r + 24'h1;
    end else begin
      us_r  <= us_r + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sink_o <= 1'b0;
    end else begin
      sink_o <= en_i && (pos_r < on_w);
    end
  end
endmodule
`default_nettype wire

/* logic/bwl_button.sv */
// bwl_button: debounced press timing and decode of button actions
// assumes button input already synchronised; ms_tick_i one pulse per ms
`timescale 1ns/1ps
`default_nettype none
module bwl_button #(
  parameter int unsigned DEB_MS = bwl_pkg::DEBOUNCE_MS,
  parameter int unsigned PUL_MS = bwl_pkg::PULSE_MS,
  parameter int unsigned S1_MS  = bwl_pkg::HOLD_1S_MS,
  parameter int unsigned S2_MS  = bwl_pkg::HOLD_2S_MS,
  parameter int unsigned S4_MS  = bwl_pkg::HOLD_4S_MS,
  parameter int unsigned S8_MS  = bwl_pkg::HOLD_8S_MS,
  parameter int unsigned S12_MS = bwl_pkg::HOLD_12S_MS
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ms_tick_i,
  // button, high while pressed
  input  wire logic       pressed_i,
  // configuration
  input  wire logic       pulse_en_i,
  input  wire logic       off_en_i,
  input  wire logic       cyc_en_i,
  input  wire logic [1:0] off_sel_i,
  input  wire logic [1:0] cyc_sel_i,
  // actions, one-cycle pulses except pulse_o
  output logic            wake_o,
  output logic            off_o,
  output logic            cycle_o,
  output logic            pulse_o
);
  logic [13:0] hold_r;
  logic [6:0]  pul_r;
  logic        was_r;

  // does the hold time match a selector, at release or at the instant
  function automatic logic hit(input logic [1:0] sel, input logic [13:0] t,
                               input logic rel, input logic [13:0] lo);
    logic r;
    r = 1'b0;
    case (sel)
      2'b00:   r = rel && t > lo && t < 14'(S4_MS);
      2'b01:   r = rel && t > 14'(S4_MS) && t < 14'(S8_MS);
      2'b10:   r = !rel && t == 14'(S8_MS);
      2'b11:   r = !rel && t == 14'(S12_MS);
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  logic rel_w;
  logic tick_w;
  assign rel_w  = was_r && !pressed_i;
  assign tick_w = pressed_i && ms_tick_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_r <= 14'h0;
      was_r  <= 1'b0;
    end else begin
      was_r <= pressed_i;
      if (!pressed_i) begin
        hold_r <= 14'h0;
      end else if (tick_w && hold_r != 14'h3FFF) begin
        hold_r <= hold_r + 14'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_o  <= 1'b0;
      off_o   <= 1'b0;
      cycle_o <= 1'b0;
    end else begin
      wake_o  <= tick_w && hold_r == 14'(DEB_MS);
      off_o   <= off_en_i &&
                 hit(off_sel_i, hold_r, rel_w, 14'(S1_MS)) &&
                 (rel_w || tick_w);
      cycle_o <= cyc_en_i &&
                 hit(cyc_sel_i, hold_r, rel_w, 14'(S2_MS)) &&
                 (rel_w || tick_w);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pul_r   <= 7'h00;
      pulse_o <= 1'b0;
    end else begin
      if (pulse_en_i && tick_w && hold_r == 14'(DEB_MS)) begin
        pul_r <= 7'(PUL_MS);
      end else if (ms_tick_i && pul_r != 7'h00) begin
        pul_r <= pul_r - 7'h01;
      end
      pulse_o <= pul_r != 7'h00;
    end
  end
endmodule
`default_nettype wire

/* tb/bwl_core_model.sv */
// bwl_core_model: storage core reporting boot ok, plus the user button
// assumes clk_i is the device clock; button lines are pulled up
`timescale 1ns/1ps
`default_nettype none
module bwl_core_model (
  // clock and core side
  input  wire logic clk_i,
  input  wire logic rst_low_i,
  input  wire logic healthy_i,
  output var logic  boot_ok_o,
  // buttons, high when released
  output var logic  btn6_low_o,
  output var logic  btn7_low_o
);
  int unsigned up_r;
  initial begin
    boot_ok_o = 1'b0;
    btn6_low_o = 1'b1;
    btn7_low_o = 1'b1;
    up_r = 0;
  end
  // a sick core never reports ready, so the watchdog must act
  always @(posedge clk_i) begin
    up_r <= rst_low_i ? up_r + 1 : 0;
    boot_ok_o <= healthy_i && rst_low_i && up_r >= 20;
  end
  task automatic press(input logic pin7, input int unsigned cyc);
    @(posedge clk_i);
    if (pin7) btn7_low_o <= 1'b0;
    else btn6_low_o <= 1'b0;
    repeat (cyc) @(posedge clk_i);
    btn6_low_o <= 1'b1;
    btn7_low_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* tb/bwl_top_test.sv */
// bwl_top_test: self-checking bench for the boot watchdog block
// assumes shortened counts: one ms is 20 cycles of the 125 MHz clock
`timescale 1ns/1ps
`default_nettype none
module bwl_top_test;
  localparam int unsigned MS = 20;
  // shortened timing in ms of MS cycles; the blink steps once per cycle
  localparam int unsigned WDS = 30, WDL = 60, ROMW = 5, DEB = 3, PUL = 4;
  localparam int unsigned T1 = 10, T2 = 20, T4 = 40, T8 = 80, T12 = 120;
  localparam int unsigned UD = 1;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i, gpio_i, gpio_o, gpio_oe_low_o;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic seq_done_i, rails_on_o, core_boot_ok_i, sys_rst_out_low_o;
  logic rom_hold_low_o, b6, b7, irq_out_low_o, button_pulse_o;
  logic deep_standby_o, healthy, p7;
  int miscompares, checked, n, k;
  bwl_top #(.WD_SHORT_MS(WDS), .WD_LONG_MS(WDL), .ROMW_MS(ROMW),
    .MS_CYC(MS), .DEB_MS(DEB), .S1_MS(T1), .S2_MS(T2), .S4_MS(T4),
    .S8_MS(T8), .S12_MS(T12), .PUL_MS(PUL), .US_DIV(UD)) i_bwl_top (
    .clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .seq_done_i(seq_done_i), .rails_on_o(rails_on_o),
    .core_boot_ok_i(core_boot_ok_i), .sys_rst_out_low_o(sys_rst_out_low_o),
    .rom_hold_low_o(rom_hold_low_o), .button_in_low_6_i(b6),
    .button_in_low_7_i(b7), .irq_out_low_o(irq_out_low_o),
    .button_pulse_o(button_pulse_o), .gpio_i(gpio_i), .gpio_o(gpio_o),
    .gpio_oe_low_o(gpio_oe_low_o), .deep_standby_o(deep_standby_o));
  bwl_core_model i_bwl_core_model (.clk_i(clk_i),
    .rst_low_i(sys_rst_out_low_o), .healthy_i(healthy),
    .boot_ok_o(core_boot_ok_i), .btn6_low_o(b6), .btn7_low_o(b7));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic summarize();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // request held until ack is sampled; cyc stays low one cycle after
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int c;
    c = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do begin
      @(posedge clk_i);
      c++;
    end while (wb_ack_o !== 1'b1 && c < 50);
    if (c >= 50) miscompares++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hF);
  endtask
  task automatic wait_for(ref logic s, input logic v, input int mx);
    n = 0;
    while (s !== v && n < mx) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task automatic boot(input logic [31:0] ctrl, input logic ok,
                      input logic go);
    rst_i <= 1'b1;
    seq_done_i <= 1'b0;
    healthy <= ok;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wr(bwl_pkg::REG_CTRL, ctrl);
    seq_done_i <= go;
  endtask
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {gpio_i, seq_done_i, healthy} = '0;
    rst_i = 1'b1;
    miscompares = 0;
    checked = 0;
    void'($urandom(32'h7eb3c2f9));
    boot(32'h1, 1'b0, 1'b0);
    chk({rails_on_o, sys_rst_out_low_o, rom_hold_low_o}, 3'h5);
    wb(1'b0, bwl_pkg::REG_CTRL, 0, 4'hF);
    chk(q, bwl_pkg::CTRL_RESET | 32'h1);
    wb(1'b0, bwl_pkg::REG_BUTTON, 0, 4'hF);
    chk(q, bwl_pkg::BTN_RESET);
    k = 8'h10 + 4 * ($urandom % 60);
    wr(k[7:0], 32'hFFFF_FFFF);
    wb(1'b0, k[7:0], 0, 4'hF);
    chk(q, 0);
    $display("test reset done");
    seq_done_i <= 1'b1;
    wait_for(sys_rst_out_low_o, 1'b1, 100);
    wait_for(sys_rst_out_low_o, 1'b0, 1000);
    chk(n >= (WDS - 1) * MS && n <= (WDS + 2) * MS, 1);
    repeat (2) @(posedge clk_i);
    chk({rails_on_o, rom_hold_low_o}, 2'h0);
    seq_done_i <= 1'b0;
    healthy <= 1'b1;
    repeat (60) @(posedge clk_i);
    chk(rails_on_o, 0);
    repeat (90) @(posedge clk_i);
    chk({rails_on_o, sys_rst_out_low_o, rom_hold_low_o}, 3'h4);
    seq_done_i <= 1'b1;
    wait_for(sys_rst_out_low_o, 1'b1, 400);
    chk(rom_hold_low_o, 1);
    repeat (700) @(posedge clk_i);
    chk({sys_rst_out_low_o, rom_hold_low_o}, 2'h3);
    wb(1'b0, bwl_pkg::REG_STATUS, 0, 4'hF);
    chk(q, {18'h0, 2'b01, 1'b0, 8'h00, bwl_pkg::BWL_RUN});
    $display("test rom recovery done");
    boot(32'h1, 1'b0, 1'b1);
    wait_for(sys_rst_out_low_o, 1'b1, 100);
    repeat (300) @(posedge clk_i);
    wr(bwl_pkg::REG_CTRL, 0);
    repeat (600) @(posedge clk_i);
    chk({rails_on_o, sys_rst_out_low_o, rom_hold_low_o}, 3'h7);
    boot(32'h5, 1'b0, 1'b1);
    wait_for(sys_rst_out_low_o, 1'b1, 100);
    wait_for(sys_rst_out_low_o, 1'b0, 1000);
    repeat (2) @(posedge clk_i);
    chk({rails_on_o, rom_hold_low_o}, 2'h1);
    $display("test watchdog options done");
    boot(32'h0, 1'b1, 1'b1);
    p7 = $urandom % 2;
    wr(bwl_pkg::REG_BUTTON, 32'h1 | {p7, 8'h0});
    wr(bwl_pkg::REG_CTRL, 32'h3000);
    i_bwl_core_model.press(p7, (DEB - 1) * MS);
    repeat (20) @(posedge clk_i);
    chk({button_pulse_o, irq_out_low_o}, 2'h1);
    i_bwl_core_model.press(p7, (DEB + 2) * MS);
    chk({button_pulse_o, irq_out_low_o}, 2'h2);
    wb(1'b0, bwl_pkg::REG_CTRL, 0, 4'hF);
    chk(q[13:12], 2'h0);
    wb(1'b1, bwl_pkg::REG_STATUS, 32'h400, 4'h2);
    @(posedge clk_i);
    chk(irq_out_low_o, 1);
    wr(bwl_pkg::REG_CTRL, 32'h4000);
    i_bwl_core_model.press(p7, (DEB + 2) * MS);
    chk(irq_out_low_o, 1);
    wr(bwl_pkg::REG_BUTTON, 32'h66 | {p7, 8'h0});
    i_bwl_core_model.press(p7, ((T4 + T8) / 2) * MS);
    wait_for(rails_on_o, 1'b0, 60);
    chk(rails_on_o, 0);
    repeat (300) @(posedge clk_i);
    chk(rails_on_o, 1);
    i_bwl_core_model.press(p7, ((T2 + T4) / 2) * MS);
    repeat (10) @(posedge clk_i);
    chk(rails_on_o, 1);
    i_bwl_core_model.press(p7, (T8 + T1) * MS);
    chk(rails_on_o, 0);
    $display("test button done");
    k = $urandom % 7;
    wr(bwl_pkg::REG_GPIO, 32'h1 << k);
    gpio_i[k] <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk(deep_standby_o, 1);
    gpio_i[k] <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk(deep_standby_o, 0);
    chk(gpio_oe_low_o, 8'hFF);
    chk(gpio_o, 8'h00);
    wr(bwl_pkg::REG_CTRL, 32'h708 | (($urandom % 8) << 4));
    repeat (50) @(posedge clk_i);
    chk(gpio_oe_low_o, 8'h7F);
    $display("test gpio and led done");
    summarize();
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    miscompares++;
    summarize();
  end
endmodule
`default_nettype wire
